//--- src/gpio_input_feature_control.sv
// Device end: pin direction, grouped source select and input features
`timescale 1ns/100ps
`include "gpio_link_map.svh"

module gpio_input_feature_control #(
   parameter int DG_PINS = `DG_PIN_COUNT,
   parameter int AG_PINS = `AG_PIN_COUNT,
   parameter int SRC_W = 3,
   parameter int ATT_W = 10,
   parameter int GAIN_W = 8,
   parameter logic [9:0] ATT_STEP = 10'h001
) (
   input wire logic clk,
   input wire logic rst_n,
   gpio_link_if.device link,
   input wire logic [15:0] dg_oe_cfg,
   input wire logic [11:0] ag_oe_cfg,
   input wire logic [8*SRC_W-1:0] dg_src_sel,
   input wire logic [3*SRC_W-1:0] ag_src_sel,
   input wire logic [(1<<SRC_W)-1:0] status_src,
   input wire gpio_pkg::pin_assign_type [gpio_pkg::FEAT_NUM-1:0] feat_cfg,
   input wire logic tx_atten_pin_mode,
   input wire logic [ATT_W-1:0] tx_atten_min,
   input wire logic [ATT_W-1:0] tx_atten_max,
   input wire logic [GAIN_W-1:0] rx_gain_min,
   input wire logic [GAIN_W-1:0] rx_gain_max,
   output logic [15:0] dg_in,
   output logic [11:0] ag_in,
   output logic obs_rx_enable,
   output logic [ATT_W-1:0] tx_atten,
   output logic [GAIN_W-1:0] rx_gain_index,
   output logic pa_ramp_up,
   output logic pa_ramp_down,
   output logic ch_power_save,
   output logic sys_power_save,
   output logic monitor_enable,
   output logic hop_event,
   output logic hop_gain_sel,
   output logic hop_freq_sel
);

   localparam int NF = gpio_pkg::FEAT_NUM;

   // ==========================================
   // Helpers
   function automatic logic [3:0] max_pin(input int f);
      if (f == gpio_pkg::FEAT_OBS_RX_EN || f == gpio_pkg::FEAT_GAIN_DEC ||
          f == gpio_pkg::FEAT_MON_EN || f == gpio_pkg::FEAT_HOP_EVT) begin
         max_pin = `LOW_RANGE_MAX_PIN;
      end else begin
         max_pin = `FULL_RANGE_MAX_PIN;
      end
   endfunction

   // Out-of-range assignment leaves the feature idle
   function automatic logic pick(input logic [15:0] v, input gpio_pkg::pin_assign_type a,
                                 input logic [3:0] lim);
      pick = a.en && (a.pin <= lim) && v[a.pin];
   endfunction

   // ==========================================
   // Pin drive: direction and grouped source select
   logic [15:0] dg_out_r;
   logic [15:0] dg_oe_r;
   logic [11:0] ag_out_r;
   logic [11:0] ag_oe_r;
   logic [15:0] dg_out_nxt;
   logic [11:0] ag_out_nxt;

   genvar i;
   generate
      for (i = 0; i < DG_PINS; i++) begin : g_dg_src
         assign dg_out_nxt[i] = status_src[dg_src_sel[(i/`DG_GROUP_SIZE)*SRC_W +: SRC_W]];
      end
      for (i = 0; i < AG_PINS; i++) begin : g_ag_src
         assign ag_out_nxt[i] = status_src[ag_src_sel[(i/`AG_GROUP_SIZE)*SRC_W +: SRC_W]];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dg_out_r <= 16'h0000;
         dg_oe_r <= 16'h0000;
         ag_out_r <= 12'h000;
         ag_oe_r <= 12'h000;
      end else begin
         dg_out_r <= dg_out_nxt;
         dg_oe_r <= dg_oe_cfg;
         ag_out_r <= ag_out_nxt;
         ag_oe_r <= ag_oe_cfg;
      end
   end

   assign link.dg_dev_out = dg_out_r;
   assign link.dg_dev_oe = dg_oe_r;
   assign link.ag_dev_out = ag_out_r;
   assign link.ag_dev_oe = ag_oe_r;

   // ==========================================
   // Input synchronisers and edge detect
   logic [15:0] dg_meta_r;
   logic [15:0] dg_sync_r;
   logic [15:0] dg_prev_r;
   logic [11:0] ag_meta_r;
   logic [11:0] ag_sync_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dg_meta_r <= 16'h0000;
         dg_sync_r <= 16'h0000;
         dg_prev_r <= 16'h0000;
         ag_meta_r <= 12'h000;
         ag_sync_r <= 12'h000;
      end else begin
         dg_meta_r <= link.dg_level;
         dg_sync_r <= dg_meta_r;
         dg_prev_r <= dg_sync_r;
         ag_meta_r <= link.ag_level;
         ag_sync_r <= ag_meta_r;
      end
   end

   // Pins driven by this end never act as controls
   logic [15:0] in_now;
   logic [15:0] in_old;
   assign in_now = dg_sync_r & ~dg_oe_r;
   assign in_old = dg_prev_r & ~dg_oe_r;

   logic [NF-1:0] lvl;
   logic [NF-1:0] rise;
   logic [NF-1:0] fall;
   logic [NF-1:0] lvl_old;

   genvar f;
   generate
      for (f = 0; f < NF; f++) begin : g_feat
         assign lvl[f] = pick(in_now, feat_cfg[f], max_pin(f));
         assign lvl_old[f] = pick(in_old, feat_cfg[f], max_pin(f));
         assign rise[f] = lvl[f] & ~lvl_old[f];
         assign fall[f] = ~lvl[f] & lvl_old[f];
      end
   endgenerate

   // ==========================================
   // Level controls and event pulses
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dg_in <= 16'h0000;
         ag_in <= 12'h000;
         obs_rx_enable <= 1'b0;
         ch_power_save <= 1'b0;
         sys_power_save <= 1'b0;
         monitor_enable <= 1'b0;
         hop_gain_sel <= 1'b0;
         hop_freq_sel <= 1'b0;
         hop_event <= 1'b0;
         pa_ramp_up <= 1'b0;
         pa_ramp_down <= 1'b0;
      end else begin
         dg_in <= in_now;
         ag_in <= ag_sync_r & ~ag_oe_r;
         obs_rx_enable <= lvl[gpio_pkg::FEAT_OBS_RX_EN];
         ch_power_save <= lvl[gpio_pkg::FEAT_CH_PSAVE];
         sys_power_save <= lvl[gpio_pkg::FEAT_SYS_PSAVE];
         monitor_enable <= lvl[gpio_pkg::FEAT_MON_EN];
         hop_gain_sel <= lvl[gpio_pkg::FEAT_HOP_GAIN];
         hop_freq_sel <= lvl[gpio_pkg::FEAT_HOP_FREQ];
         hop_event <= rise[gpio_pkg::FEAT_HOP_EVT];
         pa_ramp_up <= rise[gpio_pkg::FEAT_PA_RAMP];
         pa_ramp_down <= fall[gpio_pkg::FEAT_PA_RAMP];
      end
   end

   // ==========================================
   // Transmit attenuation stepping
   logic att_up;
   logic att_dn;
   assign att_up = tx_atten_pin_mode & rise[gpio_pkg::FEAT_ATT_INC] &
                   ~rise[gpio_pkg::FEAT_ATT_DEC];
   assign att_dn = tx_atten_pin_mode & rise[gpio_pkg::FEAT_ATT_DEC] &
                   ~rise[gpio_pkg::FEAT_ATT_INC];

   // Compare against headroom so the sum never overflows
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_atten <= `TX_ATTEN_RESET;
      end else if (att_up) begin
         if (tx_atten_max - tx_atten >= ATT_W'(ATT_STEP) && tx_atten <= tx_atten_max) begin
            tx_atten <= tx_atten + ATT_W'(ATT_STEP);
         end else begin
            tx_atten <= tx_atten_max;
         end
      end else if (att_dn) begin
         if (tx_atten - tx_atten_min >= ATT_W'(ATT_STEP) && tx_atten >= tx_atten_min) begin
            tx_atten <= tx_atten - ATT_W'(ATT_STEP);
         end else begin
            tx_atten <= tx_atten_min;
         end
      end
   end

   // ==========================================
   // Receive gain index stepping
   logic gain_up;
   logic gain_dn;
   assign gain_up = rise[gpio_pkg::FEAT_GAIN_INC] & ~rise[gpio_pkg::FEAT_GAIN_DEC];
   assign gain_dn = rise[gpio_pkg::FEAT_GAIN_DEC] & ~rise[gpio_pkg::FEAT_GAIN_INC];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_gain_index <= `RX_GAIN_RESET;
      end else if (gain_up && rx_gain_index < rx_gain_max) begin
         rx_gain_index <= rx_gain_index + GAIN_W'(1);
      end else if (gain_dn && rx_gain_index > rx_gain_min) begin
         rx_gain_index <= rx_gain_index - GAIN_W'(1);
      end
   end

endmodule // gpio_input_feature_control

//--- src/gpio_link_map.svh
// Offsets, field positions, reset values and timing counts for the pin link
`ifndef GPIO_LINK_MAP_SVH
`define GPIO_LINK_MAP_SVH

// ==========================================
// Pin counts and grouping
`define DG_PIN_COUNT 16
`define AG_PIN_COUNT 12
`define DG_GROUP_SIZE 2
`define AG_GROUP_SIZE 4
`define LOW_RANGE_MAX_PIN 4'hb
`define FULL_RANGE_MAX_PIN 4'hf

// ==========================================
// Device reset values
`define TX_ATTEN_RESET 10'h000
`define RX_GAIN_RESET 8'hff

// ==========================================
// Timing counts, in system clock cycles
`define STEP_PULSE_MIN_CYC 2

// ==========================================
// Host register offsets (APB byte addresses)
`define HOST_DG_DRIVE_OFS 12'h000
`define HOST_DG_OE_OFS 12'h004
`define HOST_AG_DRIVE_OFS 12'h008
`define HOST_AG_OE_OFS 12'h00c
`define HOST_PULSE_OFS 12'h010
`define HOST_STATUS_OFS 12'h014
`define HOST_DG_LEVEL_OFS 12'h018
`define HOST_AG_LEVEL_OFS 12'h01c
`define HOST_OBS_CTRL_OFS 12'h020

// ==========================================
// Host register fields
`define OBS_PIN_LSB 0
`define OBS_PIN_MSB 3
`define OBS_REQ_BIT 4
`define OBS_TX_EN_BIT 8
`define STATUS_BUSY_BIT 0

`endif

//--- src/gpio_pkg.sv
// Types shared by the device end of the pin link and the bench
package gpio_pkg;

   // ==========================================
   // Input features that can claim a digital pin
   typedef enum {
      FEAT_OBS_RX_EN,
      FEAT_ATT_INC,
      FEAT_ATT_DEC,
      FEAT_GAIN_INC,
      FEAT_GAIN_DEC,
      FEAT_PA_RAMP,
      FEAT_CH_PSAVE,
      FEAT_SYS_PSAVE,
      FEAT_MON_EN,
      FEAT_HOP_EVT,
      FEAT_HOP_GAIN,
      FEAT_HOP_FREQ,
      FEAT_NUM
   } feature_type;

   typedef struct packed {
      logic en;
      logic [3:0] pin;
   } pin_assign_type;

endpackage

//--- src/gpio_link_if.sv
// Pin link between the device end and the baseband processor end
`timescale 1ns/100ps
interface gpio_link_if;
   logic [15:0] dg_dev_out;
   logic [15:0] dg_dev_oe;
   logic [15:0] dg_host_out;
   logic [15:0] dg_host_oe;
   logic [11:0] ag_dev_out;
   logic [11:0] ag_dev_oe;
   logic [11:0] ag_host_out;
   logic [11:0] ag_host_oe;
   logic [15:0] dg_level;
   logic [11:0] ag_level;

   // Undriven pins resolve low
   assign dg_level = (dg_dev_oe & dg_dev_out) | (~dg_dev_oe & dg_host_oe & dg_host_out);
   assign ag_level = (ag_dev_oe & ag_dev_out) | (~ag_dev_oe & ag_host_oe & ag_host_out);

   modport device (
      output dg_dev_out,
      output dg_dev_oe,
      output ag_dev_out,
      output ag_dev_oe,
      input dg_level,
      input ag_level
   );

   modport host (
      output dg_host_out,
      output dg_host_oe,
      output ag_host_out,
      output ag_host_oe,
      input dg_level,
      input ag_level
   );
endinterface

//--- src/gpio_baseband_host.sv
// Baseband processor end: APB-controlled pin drive, step pulses, sampling
`timescale 1ns/100ps
`include "gpio_link_map.svh"

module gpio_baseband_host #(
   parameter int PULSE_CYC = `STEP_PULSE_MIN_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   gpio_link_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic tx_enable
);

   // ==========================================
   // Registers
   logic [15:0] dg_drive_r;
   logic [15:0] dg_oe_r;
   logic [11:0] ag_drive_r;
   logic [11:0] ag_oe_r;
   logic [15:0] pulse_mask_r;
   logic [7:0] pulse_cnt_r;
   logic [3:0] obs_pin_r;
   logic obs_req_r;
   logic [15:0] dg_out_r;
   logic [15:0] dg_host_oe_r;
   logic [11:0] ag_out_r;
   logic [11:0] ag_host_oe_r;

   logic setup;
   logic wr;
   logic busy;
   assign setup = psel & ~penable;
   assign wr = psel & penable & pready & pwrite;
   assign busy = pulse_cnt_r != 8'h00;

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a <= `HOST_OBS_CTRL_OFS) && (a[1:0] == 2'b00);
   endfunction

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dg_drive_r <= 16'h0000;
         dg_oe_r <= 16'h0000;
         ag_drive_r <= 12'h000;
         ag_oe_r <= 12'h000;
         obs_pin_r <= 4'h0;
         obs_req_r <= 1'b0;
         tx_enable <= 1'b0;
      end else if (wr) begin
         if (paddr == `HOST_DG_DRIVE_OFS) begin
            dg_drive_r <= pwdata[15:0];
         end else if (paddr == `HOST_DG_OE_OFS) begin
            dg_oe_r <= pwdata[15:0];
         end else if (paddr == `HOST_AG_DRIVE_OFS) begin
            ag_drive_r <= pwdata[11:0];
         end else if (paddr == `HOST_AG_OE_OFS) begin
            ag_oe_r <= pwdata[11:0];
         end else if (paddr == `HOST_OBS_CTRL_OFS) begin
            obs_pin_r <= pwdata[`OBS_PIN_MSB:`OBS_PIN_LSB];
            obs_req_r <= pwdata[`OBS_REQ_BIT];
            tx_enable <= pwdata[`OBS_TX_EN_BIT];
         end
      end
   end

   // Step pulses: each write restarts a fixed-width high pulse
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pulse_mask_r <= 16'h0000;
         pulse_cnt_r <= 8'h00;
      end else if (wr && paddr == `HOST_PULSE_OFS) begin
         pulse_mask_r <= pwdata[15:0];
         pulse_cnt_r <= 8'(PULSE_CYC);
      end else if (busy) begin
         pulse_cnt_r <= pulse_cnt_r - 8'h01;
      end
   end

   // ==========================================
   // Pin drive
   logic [15:0] obs_bit;
   logic [15:0] dg_out_nxt;
   always_comb begin
      obs_bit = 16'h0000;
      // Observation bit only while transmit is on; the registered pin lags it and outlasts tx_enable by one cycle
      obs_bit[obs_pin_r] = obs_req_r & tx_enable;
      dg_out_nxt = dg_drive_r | (busy ? pulse_mask_r : 16'h0000) | obs_bit;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dg_out_r <= 16'h0000;
         dg_host_oe_r <= 16'h0000;
         ag_out_r <= 12'h000;
         ag_host_oe_r <= 12'h000;
      end else begin
         dg_out_r <= dg_out_nxt;
         // One enable per pin; feature overlap is software's job
         dg_host_oe_r <= dg_oe_r | pulse_mask_r | obs_bit;
         ag_out_r <= ag_drive_r;
         ag_host_oe_r <= ag_oe_r;
      end
   end

   assign link.dg_host_out = dg_out_r;
   assign link.dg_host_oe = dg_host_oe_r;
   assign link.ag_host_out = ag_out_r;
   assign link.ag_host_oe = ag_host_oe_r;

   // ==========================================
   // APB slave: one wait-free access phase, data prepared in setup
   logic [31:0] rd_nxt;
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (paddr == `HOST_DG_DRIVE_OFS) begin
         rd_nxt = {16'h0000, dg_drive_r};
      end else if (paddr == `HOST_DG_OE_OFS) begin
         rd_nxt = {16'h0000, dg_oe_r};
      end else if (paddr == `HOST_AG_DRIVE_OFS) begin
         rd_nxt = {20'h00000, ag_drive_r};
      end else if (paddr == `HOST_AG_OE_OFS) begin
         rd_nxt = {20'h00000, ag_oe_r};
      end else if (paddr == `HOST_PULSE_OFS) begin
         rd_nxt = {16'h0000, pulse_mask_r};
      end else if (paddr == `HOST_STATUS_OFS) begin
         rd_nxt[`STATUS_BUSY_BIT] = busy;
      end else if (paddr == `HOST_DG_LEVEL_OFS) begin
         rd_nxt = {16'h0000, link.dg_level};
      end else if (paddr == `HOST_AG_LEVEL_OFS) begin
         rd_nxt = {20'h00000, link.ag_level};
      end else if (paddr == `HOST_OBS_CTRL_OFS) begin
         rd_nxt[`OBS_PIN_MSB:`OBS_PIN_LSB] = obs_pin_r;
         rd_nxt[`OBS_REQ_BIT] = obs_req_r;
         rd_nxt[`OBS_TX_EN_BIT] = tx_enable;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped(paddr);
         if (setup && !pwrite) begin
            prdata <= rd_nxt;
         end
      end
   end

endmodule // gpio_baseband_host

//--- verification/gpio_link_properties.sv
// Concurrent checks on the pin link and the device feature outputs
`timescale 1ns/100ps
module gpio_link_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] dg_dev_out,
   input wire logic [15:0] dg_dev_oe,
   input wire logic [15:0] dg_host_oe,
   input wire logic [11:0] ag_dev_out,
   input wire logic [11:0] ag_dev_oe,
   input wire logic [9:0] tx_atten,
   input wire logic [7:0] rx_gain_index,
   input wire logic pa_ramp_up,
   input wire logic pa_ramp_down,
   input wire logic hop_event
);
   logic [7:0] pair_bad;
   logic [2:0] quad_bad;

   // ==========================================
   // Group helpers: members of a fully driven group must agree
   always_comb begin
      for (int g = 0; g < 8; g++)
         pair_bad[g] = dg_dev_oe[2*g] & dg_dev_oe[2*g+1] & (dg_dev_out[2*g] ^ dg_dev_out[2*g+1]);
      for (int q = 0; q < 3; q++)
         quad_bad[q] = (&ag_dev_oe[4*q+:4]) & (|ag_dev_out[4*q+:4]) & ~(&ag_dev_out[4*q+:4]);
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ==========================================
   // Properties
   // Past value check skipped on the edge just after a reset
   property p_atten_step;
      $changed(tx_atten) && $past(rst_n) |->
         (tx_atten == $past(tx_atten) + 10'h001 && tx_atten != 10'h000) ||
         (tx_atten == $past(tx_atten) - 10'h001 && tx_atten != 10'h3ff);
   endproperty
   a_atten_step: assert property (p_atten_step)
      else $error("attenuation moved by other than one step");
   property p_gain_step;
      $changed(rx_gain_index) && $past(rst_n) |->
         (rx_gain_index == $past(rx_gain_index) + 8'h01 && rx_gain_index != 8'h00) ||
         (rx_gain_index == $past(rx_gain_index) - 8'h01 && rx_gain_index != 8'hff);
   endproperty
   a_gain_step: assert property (p_gain_step)
      else $error("gain index moved by other than one step");
   property p_gain_single;
      $changed(rx_gain_index) && $past(rst_n) |=> $stable(rx_gain_index);
   endproperty
   a_gain_single: assert property (p_gain_single)
      else $error("gain index stepped twice in a row");
   property p_ramp_pulse;
      pa_ramp_up |-> !pa_ramp_down ##1 !pa_ramp_up;
   endproperty
   a_ramp_pulse: assert property (p_ramp_pulse)
      else $error("ramp trigger not a lone pulse");
   property p_hop_pulse;
      hop_event |=> !hop_event;
   endproperty
   a_hop_pulse: assert property (p_hop_pulse)
      else $error("hop event longer than one cycle");
   property p_dg_pairs;
      pair_bad == 8'h00;
   endproperty
   a_dg_pairs: assert property (p_dg_pairs)
      else $error("digital pair carries two sources");
   property p_ag_quads;
      quad_bad == 3'h0;
   endproperty
   a_ag_quads: assert property (p_ag_quads)
      else $error("analog group carries two sources");
   property p_reset_idle;
      $rose(rst_n) |-> dg_dev_oe == 16'h0000 && dg_host_oe == 16'h0000 &&
         ag_dev_oe == 12'h000 && tx_atten == 10'h000 && rx_gain_index == 8'hff;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("outputs not idle after reset");
endmodule // gpio_link_properties

//--- verification/tb.sv
// Self-checking bench for both ends of the pin link
`timescale 1ns/100ps
`include "gpio_link_map.svh"
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic pready, pslverr, rerr, tx_enable;
   logic [15:0] dg_oe_cfg = 16'h0000, dg_in, exp_dg;
   logic [11:0] ag_oe_cfg = 12'h000, ag_in, exp_ag;
   logic [23:0] dg_src_sel = 24'h7ca000;
   logic [8:0] ag_src_sel = 9'h0d0;
   logic [7:0] status_src = 8'ha6;
   gpio_pkg::pin_assign_type [gpio_pkg::FEAT_NUM-1:0] feat_cfg = '0;
   logic tx_atten_pin_mode = 1'b0;
   logic [9:0] tx_atten_min = 10'h000, tx_atten_max = 10'h002, tx_atten;
   logic [7:0] rx_gain_min = 8'hfd, rx_gain_max = 8'hff, rx_gain_index;
   logic obs_rx_enable, pa_ramp_up, pa_ramp_down, ch_power_save, sys_power_save;
   logic monitor_enable, hop_event, hop_gain_sel, hop_freq_sel;
   int n_errors = 0, n_tests = 0, n_up = 0, n_dn = 0, n_hop = 0;

   always #50 clk = ~clk;
   always @(posedge clk) begin
      if (pa_ramp_up === 1'b1) n_up++;
      if (pa_ramp_down === 1'b1) n_dn++;
      if (hop_event === 1'b1) n_hop++;
   end

   gpio_link_if gpio_link_if_i ();
   gpio_input_feature_control gpio_input_feature_control_i (.clk(clk), .rst_n(rst_n),
      .link(gpio_link_if_i), .dg_oe_cfg(dg_oe_cfg), .ag_oe_cfg(ag_oe_cfg),
      .dg_src_sel(dg_src_sel), .ag_src_sel(ag_src_sel), .status_src(status_src),
      .feat_cfg(feat_cfg), .tx_atten_pin_mode(tx_atten_pin_mode),
      .tx_atten_min(tx_atten_min), .tx_atten_max(tx_atten_max), .rx_gain_min(rx_gain_min),
      .rx_gain_max(rx_gain_max), .dg_in(dg_in), .ag_in(ag_in), .obs_rx_enable(obs_rx_enable),
      .tx_atten(tx_atten), .rx_gain_index(rx_gain_index), .pa_ramp_up(pa_ramp_up),
      .pa_ramp_down(pa_ramp_down), .ch_power_save(ch_power_save),
      .sys_power_save(sys_power_save), .monitor_enable(monitor_enable),
      .hop_event(hop_event), .hop_gain_sel(hop_gain_sel), .hop_freq_sel(hop_freq_sel));
   gpio_baseband_host gpio_baseband_host_i (.clk(clk), .rst_n(rst_n), .link(gpio_link_if_i),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_enable(tx_enable));
   gpio_link_properties gpio_link_properties_i (.clk(clk), .rst_n(rst_n),
      .dg_dev_out(gpio_link_if_i.dg_dev_out), .dg_dev_oe(gpio_link_if_i.dg_dev_oe),
      .dg_host_oe(gpio_link_if_i.dg_host_oe), .ag_dev_out(gpio_link_if_i.ag_dev_out),
      .ag_dev_oe(gpio_link_if_i.ag_dev_oe), .tx_atten(tx_atten),
      .rx_gain_index(rx_gain_index), .pa_ramp_up(pa_ramp_up), .pa_ramp_down(pa_ramp_down),
      .hop_event(hop_event));

   // ==========================================
   // Access tasks
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Host pulse lasts two cycles; wait covers the three-edge input path
   task automatic pulse(input int pin);
      apb(1'b1, `HOST_PULSE_OFS, 32'h1 << pin);
      wt(8);
   endtask
   task automatic feat(input gpio_pkg::feature_type f, input logic [3:0] pin);
      feat_cfg[f] <= {1'b1, pin};
      wt(2);
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #(100 * 5000);
      n_errors++;
      $display("mismatch watchdog expected done seen hang");
      stop_test;
   end

   // ==========================================
   // Test sequence
   initial begin
      wt(20);
      rst_n <= 1'b1;
      wt(2);
      chk("rx_gain_index", 32'hff, rx_gain_index);
      apb(1'b0, 12'h024, 32'h0);
      chk("pslverr", 32'h1, rerr);
      chk("unmapped", 32'h0, rdata);
      dg_oe_cfg <= 16'hff00;
      ag_oe_cfg <= 12'hf00;
      apb(1'b1, `HOST_DG_OE_OFS, 32'h00ff);
      apb(1'b1, `HOST_DG_DRIVE_OFS, 32'h00a5);
      apb(1'b1, `HOST_AG_OE_OFS, 32'h00ff);
      apb(1'b1, `HOST_AG_DRIVE_OFS, 32'h003c);
      wt(6);
      for (int p = 0; p < 16; p++)
         exp_dg[p] = dg_oe_cfg[p] ? status_src[dg_src_sel[3*(p/2)+:3]] : 1'(16'h00a5 >> p);
      for (int p = 0; p < 12; p++)
         exp_ag[p] = ag_oe_cfg[p] ? status_src[ag_src_sel[3*(p/4)+:3]] : 1'(12'h03c >> p);
      chk("dg_in", 32'h00a5, dg_in);
      chk("ag_in", 32'h003c, ag_in);
      apb(1'b0, `HOST_DG_LEVEL_OFS, 32'h0);
      chk("dg_level", exp_dg, rdata);
      apb(1'b0, `HOST_AG_LEVEL_OFS, 32'h0);
      chk("ag_level", exp_ag, rdata);
      dg_oe_cfg <= 16'h0000;
      ag_oe_cfg <= 12'h000;
      apb(1'b1, `HOST_DG_OE_OFS, 32'hffff);
      apb(1'b1, `HOST_DG_DRIVE_OFS, 32'h0);
      wt(6);
      // One pin per feature, so no pin is claimed twice
      feat(gpio_pkg::FEAT_ATT_INC, 4'hf);
      feat(gpio_pkg::FEAT_ATT_DEC, 4'h0);
      feat(gpio_pkg::FEAT_GAIN_INC, 4'h5);
      feat(gpio_pkg::FEAT_GAIN_DEC, 4'hb);
      feat(gpio_pkg::FEAT_PA_RAMP, 4'he);
      feat(gpio_pkg::FEAT_SYS_PSAVE, 4'h7);
      feat(gpio_pkg::FEAT_CH_PSAVE, 4'h8);
      feat(gpio_pkg::FEAT_MON_EN, 4'h3);
      feat(gpio_pkg::FEAT_HOP_EVT, 4'ha);
      feat(gpio_pkg::FEAT_HOP_GAIN, 4'hc);
      feat(gpio_pkg::FEAT_HOP_FREQ, 4'h9);
      feat(gpio_pkg::FEAT_OBS_RX_EN, 4'h2);
      tx_atten_pin_mode <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         pulse(15);
         chk("tx_atten", (i < 2) ? i + 1 : 2, tx_atten);
      end
      for (int i = 0; i < 3; i++) begin
         pulse(0);
         chk("tx_atten", (i < 2) ? 1 - i : 0, tx_atten);
      end
      tx_atten_pin_mode <= 1'b0;
      pulse(15);
      chk("tx_atten", 32'h0, tx_atten);
      pulse(5);
      chk("rx_gain_index", 32'hff, rx_gain_index);
      for (int i = 0; i < 3; i++) begin
         pulse(11);
         chk("rx_gain_index", (i < 2) ? 8'hfe - i : 8'hfd, rx_gain_index);
      end
      // Pin 13 is free, so the refused assignment claims no shared pin
      feat(gpio_pkg::FEAT_GAIN_DEC, 4'hd);
      pulse(13);
      chk("rx_gain_index", 32'hfd, rx_gain_index);
      feat(gpio_pkg::FEAT_GAIN_DEC, 4'hb);
      apb(1'b1, `HOST_DG_DRIVE_OFS, 32'h0020);
      wt(20);
      chk("rx_gain_index", 32'hfe, rx_gain_index);
      apb(1'b1, `HOST_DG_DRIVE_OFS, 32'h1388);
      wt(6);
      chk("levels", 32'h1f, {ch_power_save, sys_power_save, monitor_enable,
         hop_gain_sel, hop_freq_sel});
      apb(1'b1, `HOST_DG_DRIVE_OFS, 32'h0);
      wt(6);
      chk("levels", 32'h0, {ch_power_save, sys_power_save, monitor_enable,
         hop_gain_sel, hop_freq_sel});
      pulse(10);
      chk("hop_event", 32'h1, n_hop);
      apb(1'b1, `HOST_DG_DRIVE_OFS, 32'h4000);
      wt(10);
      chk("ramp_up", 32'h1, n_up);
      chk("ramp_down", 32'h0, n_dn);
      apb(1'b1, `HOST_DG_DRIVE_OFS, 32'h0);
      wt(10);
      chk("ramp_down", 32'h1, n_dn);
      apb(1'b1, `HOST_OBS_CTRL_OFS, 32'h0112);
      wt(6);
      chk("obs_rx_enable", 32'h1, obs_rx_enable);
      chk("tx_enable", 32'h1, tx_enable);
      apb(1'b1, `HOST_OBS_CTRL_OFS, 32'h0100);
      wt(6);
      chk("obs_rx_enable", 32'h0, obs_rx_enable);
      feat(gpio_pkg::FEAT_OBS_RX_EN, 4'hd);
      apb(1'b1, `HOST_OBS_CTRL_OFS, 32'h011d);
      wt(6);
      chk("obs_rx_enable", 32'h0, obs_rx_enable);
      stop_test;
   end
endmodule // tb
